// [src/usc_regs.svh]
// Purpose: register offsets, field positions, reset values and counts
// Assumes: byte addresses on a 32-bit Avalon-MM slave, data in bits 7:0
// Notes: one word per register; bits above 7 read as zero
`ifndef USC_REGS_SVH
`define USC_REGS_SVH

// Register byte offsets
`define USC_OFF_CONTROL     8'h00
`define USC_OFF_CONFIG      8'h04
`define USC_OFF_STATUS      8'h08
`define USC_OFF_FLAGS       8'h0C
`define USC_OFF_ADDRESS     8'h10
`define USC_OFF_FRAME_LOW   8'h14
`define USC_OFF_FRAME_HIGH  8'h18
`define USC_OFF_EP_BASE     8'h20
`define USC_OFF_EP_LAST     8'h3C

// Control register fields
`define USC_CTL_ENABLE      0
`define USC_CTL_SUSPEND     1
// Configuration register fields
`define USC_CFG_PPM_LO      0
`define USC_CFG_PPM_HI      1
`define USC_CFG_FS          2
`define USC_CFG_PULLUP      4
`define USC_CFG_EYE         7
// Flag register fields (write one to clear)
`define USC_FLG_TRN         0
`define USC_FLG_BUSRST      1
// Endpoint control fields
`define USC_EP_STALL        0
`define USC_EP_IN           1
`define USC_EP_OUT          2
`define USC_EP_CONDIS       3
`define USC_EP_HSHK         4

// Reset value and FIFO depth
`define USC_RST_BYTE        8'h00
`define USC_FIFO_DEPTH      3'h4

// Eye pattern bit periods at 200 MHz, bit rates in kHz
`define USC_CLK_KHZ         200000
`define USC_FS_KHZ          12000
`define USC_LS_KHZ          1500
`define USC_FS_DIV          (`USC_CLK_KHZ / `USC_FS_KHZ)
`define USC_LS_DIV          (`USC_CLK_KHZ / `USC_LS_KHZ)

`endif

// [src/usc_pkg.sv]
// Purpose: types shared by the configuration and status block
// Assumes: serial engine side is synchronous to clk_sys_in
// Notes: offsets and counts live in usc_regs.svh
package usc_pkg;

   // Token kinds seen by the serial engine
   typedef enum logic [1:0] {
      TOK_OUT   = 2'h0,
      TOK_IN    = 2'h1,
      TOK_SETUP = 2'h2
   } usc_tok_type;

   // Answer to an endpoint request
   typedef enum logic [1:0] {
      RSP_IGNORE = 2'h0,
      RSP_NAK    = 2'h1,
      RSP_ACCEPT = 2'h2
   } usc_rsp_type;

   // Done-flag sequencer, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_LOAD = 3'h2,
      ST_FLAG = 3'h4
   } usc_state_type;

   // One completed transaction
   typedef struct packed {
      logic [3:0] endp;
      logic       dir;
      logic       pp_ptr;
   } usc_status_type;

   // Endpoint request from the serial engine
   typedef struct packed {
      usc_tok_type kind;
      logic [6:0]  addr;
      logic [3:0]  endp;
   } usc_req_type;

   // Registered answer back to the serial engine
   typedef struct packed {
      usc_rsp_type kind;
      logic        handshake;
   } usc_resp_type;

endpackage

// [src/usc_sie_cfg.sv]
// Purpose: configuration, status FIFO, endpoint control and address logic
// Assumes: Avalon-MM slave, engine strobes synchronous to clk_sys_in
// Notes: every access takes two cycles, waitrequest high in the first
//        software polls the flags
`timescale 1ns/1ps
`include "usc_regs.svh"
`default_nettype none

module usc_sie_cfg (
   input  wire logic                  clk_sys_in,
   input  wire logic                  sys_rst_in,

   // Avalon-MM slave
   input  wire logic [7:0]            avs_address_in,
   input  wire logic                  avs_read_in,
   input  wire logic                  avs_write_in,
   input  wire logic [31:0]           avs_writedata_in,
   input  wire logic [3:0]            avs_byteenable_in,
   output logic [31:0]                avs_readdata_out,
   output logic                       avs_waitrequest_out,

   // Serial engine events
   input  wire logic                  trn_done_in,
   input  wire usc_pkg::usc_status_type trn_status_in,
   input  wire logic                  stall_issued_in,
   input  wire logic [2:0]            stall_endp_in,
   input  wire logic                  sof_in,
   input  wire logic [10:0]           sof_frame_in,
   input  wire logic                  bus_reset_in,
   input  wire logic                  req_valid_in,
   input  wire usc_pkg::usc_req_type  req_in,
   output logic                       resp_valid_out,
   output usc_pkg::usc_resp_type      resp_out,

   // Transceiver and buffer control
   output logic                       full_speed_out,
   output logic                       pullup_on_out,
   output logic [1:0]                 pingpong_mode_out,
   output logic                       pingpong_clear_out,
   output logic                       eye_dp_out,
   output logic                       eye_dm_out,
   output logic                       eye_oe_n_out
);
   import usc_pkg::*;

   // Bus access
   logic        ack_reg;              // Second cycle of a bus access
   logic        wr_en;                // Write takes effect this edge
   logic        rd_en;                // Read data captured this edge
   logic        lane0;                // Low byte lane written
   logic [7:0]  wbyte;                // Low byte of write data

   // Registers seen by software
   logic [7:0]  control_reg;          // Enable and suspend
   logic [7:0]  usb_config_reg;       // Speed, pull-up, ping-pong, eye
   logic [7:0]  device_address_reg;   // Decoded device address
   logic [7:0]  frame_number_low_reg; // Frame number bits 7:0
   logic [2:0]  frame_number_high_reg;// Frame number bits 10:8

   // Flags and endpoints
   logic        bus_reset_flag_reg;   // Sticky bus reset seen
   logic [4:0]  ep_reg [8];           // Endpoint control registers

   // Status FIFO
   usc_status_type fifo_mem [4];      // Status FIFO storage
   logic [1:0]  wr_ptr_reg;           // FIFO write pointer
   logic [1:0]  rd_ptr_reg;           // FIFO read pointer
   logic [2:0]  count_reg;            // FIFO fill level
   usc_status_type transfer_status_reg; // Head of FIFO seen by software
   usc_state_type state_reg;          // Done-flag sequencer

   // FIFO strobes
   logic        trn_clear;            // Firmware clears the done flag
   logic        push;                 // Completion enters FIFO
   logic        pop;                  // Head leaves FIFO
   logic        fifo_full;            // Four entries waiting

   // Enable and eye pattern
   logic        module_enable;        // Module active
   logic        enable_d_reg;         // Enable, one cycle late
   logic        eye_active;           // Eye pattern running
   logic [7:0]  eye_cnt_reg;          // Bit period divider
   logic        eye_phase_reg;        // Current symbol

   // Bus strobes, decoded once
   assign module_enable = control_reg[`USC_CTL_ENABLE];
   assign wr_en = avs_write_in & ack_reg;
   assign rd_en = avs_read_in & ~ack_reg;
   assign lane0 = avs_byteenable_in[0];
   assign wbyte = avs_writedata_in[7:0];
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;

   // Fixed latency; masters still wait
   // Access handshake: one wait cycle, then release
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in)
         ack_reg <= 1'b0;
      else
         ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
   end

   // Read data, captured in the wait cycle; unmapped reads give zero
   // Data stands from the same edge that drops waitrequest
   // Upper 24 bits always zero
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in)
         avs_readdata_out <= 32'h0;
      else if (rd_en) begin
         avs_readdata_out <= 32'h0;
         unique case (avs_address_in)
            `USC_OFF_CONTROL:    avs_readdata_out[7:0] <= control_reg;
            `USC_OFF_CONFIG:     avs_readdata_out[7:0] <= usb_config_reg;
            // Head entry: endpoint, direction, ping-pong pointer
            `USC_OFF_STATUS:     avs_readdata_out[7:0] <=
               {1'b0, transfer_status_reg, 1'b0};
            `USC_OFF_FLAGS:      avs_readdata_out[1:0] <=
               {bus_reset_flag_reg, state_reg == ST_FLAG};
            `USC_OFF_ADDRESS:    avs_readdata_out[7:0] <= device_address_reg;
            `USC_OFF_FRAME_LOW:  avs_readdata_out[7:0] <= frame_number_low_reg;
            `USC_OFF_FRAME_HIGH: avs_readdata_out[2:0] <= frame_number_high_reg;
            // Endpoint window, word aligned
            default: begin
               if (avs_address_in >= `USC_OFF_EP_BASE &&
                   avs_address_in <= `USC_OFF_EP_LAST &&
                   avs_address_in[1:0] == 2'h0)
                  avs_readdata_out[4:0] <= ep_reg[avs_address_in[4:2]];
            end
         endcase
      end
   end

   // Control register; suspend doubles as the not-configured state
   // Other bits read as zero
   // Writes need byte lane 0
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in)
         control_reg <= `USC_RST_BYTE;
      else if (wr_en && lane0 && avs_address_in == `USC_OFF_CONTROL)
         control_reg <= {6'h0, wbyte[1:0]};
   end

   // Configuration register, expected static while enabled
   // Speed change while on is not blocked
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in)
         usb_config_reg <= `USC_RST_BYTE;
      else if (wr_en && lane0 && avs_address_in == `USC_OFF_CONFIG)
         usb_config_reg <= wbyte & 8'h97;
   end

   // Transceiver controls follow the configuration bits
   // Registered: no glitch on bus writes
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         full_speed_out     <= 1'b0;
         pullup_on_out      <= 1'b0;
         pingpong_mode_out  <= 2'h0;
         pingpong_clear_out <= 1'b0;
         enable_d_reg       <= 1'b0;
      end else begin
         full_speed_out    <= usb_config_reg[`USC_CFG_FS];
         // Pull-ups never float onto the bus while disabled or suspended
         pullup_on_out     <= usb_config_reg[`USC_CFG_PULLUP] &
                              module_enable & ~control_reg[`USC_CTL_SUSPEND];
         // Mode passes straight through
         pingpong_mode_out <= usb_config_reg[`USC_CFG_PPM_HI:`USC_CFG_PPM_LO];
         enable_d_reg      <= module_enable;
         // One pulse on the rising edge of enable
         pingpong_clear_out <= module_enable & ~enable_d_reg;
      end
   end

   // Eye pattern: alternate symbols at the selected bit rate
   // Either bit low stops the pattern
   assign eye_active = usb_config_reg[`USC_CFG_EYE] & module_enable;

   // Restarts while off: whole first bit
   // Bit periods rounded down to whole clocks
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || !eye_active) begin
         eye_cnt_reg   <= 8'h0;
         eye_phase_reg <= 1'b0;
      end else if (eye_cnt_reg == (usb_config_reg[`USC_CFG_FS] ?
                   8'(`USC_FS_DIV - 1) : 8'(`USC_LS_DIV - 1))) begin
         // Bit period over
         eye_cnt_reg   <= 8'h0;
         eye_phase_reg <= ~eye_phase_reg;
      end else
         eye_cnt_reg <= eye_cnt_reg + 8'h1;
   end

   // Phase 0 is J at low speed and K at full speed, so D+ tracks phase
   // D- is the inverse of D+ while the pattern runs; both low when off
   // Turnaround to transmit not modelled
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         eye_dp_out   <= 1'b0;
         eye_dm_out   <= 1'b0;
         eye_oe_n_out <= 1'b1;
      end else begin
         eye_dp_out   <= eye_active & eye_phase_reg;
         eye_dm_out   <= eye_active & ~eye_phase_reg;
         eye_oe_n_out <= ~eye_active;
      end
   end

   // Status FIFO bookkeeping; a completion arriving when full is lost
   // Count runs 0 to 4, pointers wrap
   // Push and pop together: count holds
   // Firmware clear is the only pop
   assign fifo_full = (count_reg == `USC_FIFO_DEPTH);
   assign trn_clear = wr_en && lane0 && avs_address_in == `USC_OFF_FLAGS &&
                      wbyte[`USC_FLG_TRN];
   assign pop  = (state_reg == ST_FLAG) & trn_clear;
   assign push = trn_done_in & ~fifo_full;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         wr_ptr_reg <= 2'h0;
         rd_ptr_reg <= 2'h0;
         count_reg  <= 3'h0;
      end else begin
         if (push) begin
            // Count marks valid entries
            fifo_mem[wr_ptr_reg] <= trn_status_in;
            wr_ptr_reg <= wr_ptr_reg + 2'h1;
         end
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + 2'h1;
         count_reg <= count_reg + {2'h0, push} - {2'h0, pop};
      end
   end

   // Done-flag sequencer: load head, then raise flag; clear pops
   // Data loads on the same edge that raises the flag
   // A clear while the flag is low is void
   // Re-raise: IDLE, LOAD, FLAG
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state_reg           <= ST_IDLE;
         transfer_status_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               // Empty FIFO keeps the flag down
               if (count_reg != 3'h0)
                  state_reg <= ST_LOAD;
            end
            ST_LOAD: begin
               // Head copied out
               transfer_status_reg <= fifo_mem[rd_ptr_reg];
               state_reg <= ST_FLAG;
            end
            ST_FLAG: begin
               // Re-raise takes two cycles, well inside six
               if (pop)
                  state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Device address: cleared by bus reset or device reset
   // Bus reset beats a same-cycle write
   // Bit 7 always reads zero
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || bus_reset_in)
         device_address_reg <= `USC_RST_BYTE;
      else if (wr_en && lane0 && avs_address_in == `USC_OFF_ADDRESS)
         device_address_reg <= {1'b0, wbyte[6:0]};
   end

   // Bus reset flag: the set wins over a clear in the same cycle
   // Written one clears, zero keeps
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in)
         bus_reset_flag_reg <= 1'b0;
      else if (bus_reset_in)
         bus_reset_flag_reg <= 1'b1;
      else if (wr_en && lane0 && avs_address_in == `USC_OFF_FLAGS &&
               wbyte[`USC_FLG_BUSRST])
         bus_reset_flag_reg <= 1'b0;
   end

   // Frame number latched on SOF; stale while suspended
   // Software waits for the next frame
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         frame_number_low_reg  <= `USC_RST_BYTE;
         frame_number_high_reg <= 3'h0;
      end else if (sof_in && !control_reg[`USC_CTL_SUSPEND]) begin
         // Both halves move together
         frame_number_low_reg  <= sof_frame_in[7:0];
         frame_number_high_reg <= sof_frame_in[10:8];
      end
   end

   // Endpoint control registers, one per endpoint pair
   // Endpoint n at base plus 4n
   for (genvar n = 0; n < 8; n++) begin : g_ep
      always_ff @(posedge clk_sys_in) begin
         if (sys_rst_in)
            ep_reg[n] <= 5'h0;
         else begin
            // Write replaces all five bits
            if (wr_en && lane0 && avs_address_in == `USC_OFF_EP_BASE + 8'(n * 4))
               ep_reg[n] <= wbyte[4:0];
            // Engine stall beats a firmware clear in the same cycle
            if (stall_issued_in && stall_endp_in == 3'(n))
               ep_reg[n][`USC_EP_STALL] <= 1'b1;
         end
      end
   end

   // Request decode: address, endpoint enables, then FIFO room
   // Answer always one cycle later
   // Endpoints above 7 never decode
   // Disabled module ignores all
   // Handshake passed on even if ignored
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         resp_valid_out <= 1'b0;
         resp_out       <= '{kind: RSP_IGNORE, handshake: 1'b0};
      end else begin
         resp_valid_out     <= req_valid_in;
         resp_out.handshake <= ep_reg[req_in.endp[2:0]][`USC_EP_HSHK];
         if (!req_valid_in || !module_enable || req_in.endp[3] ||
             {1'b0, req_in.addr} != device_address_reg)
            resp_out.kind <= RSP_IGNORE;
         else if ((req_in.kind == TOK_OUT &&
                   !ep_reg[req_in.endp[2:0]][`USC_EP_OUT]) ||
                  (req_in.kind == TOK_IN &&
                   !ep_reg[req_in.endp[2:0]][`USC_EP_IN]) ||
                  (req_in.kind == TOK_SETUP &&
                   (ep_reg[req_in.endp[2:0]][`USC_EP_CONDIS] ||
                    !ep_reg[req_in.endp[2:0]][`USC_EP_IN] ||
                    !ep_reg[req_in.endp[2:0]][`USC_EP_OUT])))
            resp_out.kind <= RSP_IGNORE;
         // Room check comes last
         else if (fifo_full)
            resp_out.kind <= RSP_NAK;
         else
            resp_out.kind <= RSP_ACCEPT;
      end
   end

endmodule

`default_nettype wire

// [dv/usc_sie_cfg_assertions.sv]
// Purpose: port-level checks for usc_sie_cfg
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module usc_sie_cfg_assertions (
   input wire logic        clk_sys_in,
   input wire logic        sys_rst_in,
   input wire logic        avs_read_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        req_valid_in,
   input wire logic        resp_valid_out,
   input wire logic        pingpong_clear_out,
   input wire logic        eye_dp_out,
   input wire logic        eye_dm_out,
   input wire logic        eye_oe_n_out
);
   // Single domain, so clock and reset are named once
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);
   a_resp_next: assert property (req_valid_in |=> resp_valid_out)
      else $error("no answer one cycle after request");
   a_resp_cause: assert property (resp_valid_out |-> $past(req_valid_in))
      else $error("answer without request");
   a_wait_first: assert property ($rose(avs_read_in) |-> avs_waitrequest_out)
      else $error("read answered in first cycle");
   a_wait_once: assert property (avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("wait held beyond one cycle");
   a_read_upper: assert property (
      avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_eye_pair: assert property (!eye_oe_n_out |-> eye_dm_out != eye_dp_out)
      else $error("eye lines not complementary");
   a_eye_start: assert property ($fell(eye_oe_n_out) |-> !eye_dp_out)
      else $error("eye pattern starts on wrong level");
   a_eye_toggle: assert property (
      !eye_oe_n_out && $changed(eye_dp_out)
      |-> ##[1:140] ($changed(eye_dp_out) || eye_oe_n_out))
      else $error("eye pattern stopped toggling");
   a_clear_pulse: assert property (pingpong_clear_out |=> !pingpong_clear_out)
      else $error("pointer clear longer than one cycle");
endmodule

bind usc_sie_cfg usc_sie_cfg_assertions i_usc_sie_cfg_assertions (
   .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .avs_read_in(avs_read_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .req_valid_in(req_valid_in), .resp_valid_out(resp_valid_out),
   .pingpong_clear_out(pingpong_clear_out), .eye_dp_out(eye_dp_out),
   .eye_dm_out(eye_dm_out), .eye_oe_n_out(eye_oe_n_out)
);
`default_nettype wire

// [dv/usc_host_model.sv]
// Purpose: bus-side stand-in that raises engine events and requests
// Assumes: tasks are entered right after a rising edge
// Notes: idle data lines carry inverted values, never stale ones
`timescale 1ns/1ps
`default_nettype none
module usc_host_model (
   input  wire logic                   clk_sys_in,
   output var logic                    trn_done_out,
   output var usc_pkg::usc_status_type trn_status_out,
   output var logic                    stall_out,
   output var logic [2:0]              stall_endp_out,
   output var logic                    sof_out,
   output var logic [10:0]             sof_frame_out,
   output var logic                    bus_reset_out,
   output var logic                    req_valid_out,
   output var usc_pkg::usc_req_type    req_out,
   input  wire logic                   resp_valid_in,
   input  wire usc_pkg::usc_resp_type  resp_in
);
   import usc_pkg::*;
   // Quiet bus at time zero
   initial begin
      {trn_done_out, trn_status_out, stall_out, stall_endp_out} = '0;
      {sof_out, sof_frame_out, bus_reset_out, req_valid_out, req_out} = '0;
   end
   // Completion strobe; spacing of two cycles per entry
   task automatic done(input logic [3:0] e, input logic d, input logic p);
      trn_done_out <= 1'b1;
      trn_status_out <= {e, d, p};
      @(posedge clk_sys_in);
      trn_done_out <= 1'b0;
      trn_status_out <= ~{e, d, p};
      @(posedge clk_sys_in);
   endtask
   // Event strobe: k bit0 stall, bit1 frame start, bit2 bus reset
   task automatic ev(input logic [2:0] k, input logic [10:0] v);
      {bus_reset_out, sof_out, stall_out} <= k;
      stall_endp_out <= v[2:0];
      sof_frame_out <= v;
      @(posedge clk_sys_in);
      {bus_reset_out, sof_out, stall_out} <= 3'h0;
      stall_endp_out <= ~v[2:0];
      sof_frame_out <= ~v;
      @(posedge clk_sys_in);
   endtask
   // Token request; answer sampled one cycle after it is taken
   task automatic req(input usc_tok_type k, input logic [6:0] a, input logic [3:0] e,
                      output usc_resp_type r, output logic v);
      req_valid_out <= 1'b1;
      req_out <= {k, a, e};
      @(posedge clk_sys_in);
      req_valid_out <= 1'b0;
      req_out <= ~{k, a, e};
      @(posedge clk_sys_in);
      r = resp_in;
      v = resp_valid_in;
   endtask
endmodule
`default_nettype wire

// [dv/tb_usc_sie_cfg.sv]
// Purpose: self-checking bench for usc_sie_cfg
// Assumes: usc_host_model drives the engine side
// Notes: register traffic over Avalon-MM, run cut at 20000 cycles
`timescale 1ns/1ps
`include "usc_regs.svh"
`default_nettype none
module tb_usc_sie_cfg;
   import usc_pkg::*;
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] adr = 8'h00;
   logic avs_rd = 1'b0;
   logic avs_wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'hF; // Byte enable, dropped once on purpose
   logic [31:0] rdat, avs_readdata_out;
   logic avs_waitrequest_out, trn_done, stall, sof, bus_rst, req_v, resp_v;
   logic full_speed_out, pullup_on_out, pingpong_clear_out;
   logic eye_dp_out, eye_dm_out, eye_oe_n_out;
   logic [1:0] pingpong_mode_out;
   logic [2:0] stall_endp;
   logic [10:0] sof_frame;
   usc_status_type trn_status;
   usc_req_type req_d;
   usc_resp_type resp_d, lr;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int i, n;
   // 200 MHz clock
   always #2.5 clk_sys_in = ~clk_sys_in;
   usc_sie_cfg i_usc_sie_cfg (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
      .avs_read_in(avs_rd), .avs_write_in(avs_wr), .avs_writedata_in(wdat),
      .avs_byteenable_in(be), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .trn_done_in(trn_done),
      .trn_status_in(trn_status), .stall_issued_in(stall), .stall_endp_in(stall_endp),
      .sof_in(sof), .sof_frame_in(sof_frame), .bus_reset_in(bus_rst),
      .req_valid_in(req_v), .req_in(req_d), .resp_valid_out(resp_v), .resp_out(resp_d),
      .full_speed_out(full_speed_out), .pullup_on_out(pullup_on_out),
      .pingpong_mode_out(pingpong_mode_out), .pingpong_clear_out(pingpong_clear_out),
      .eye_dp_out(eye_dp_out), .eye_dm_out(eye_dm_out), .eye_oe_n_out(eye_oe_n_out));
   usc_host_model i_usc_host_model (
      .clk_sys_in(clk_sys_in), .trn_done_out(trn_done), .trn_status_out(trn_status),
      .stall_out(stall), .stall_endp_out(stall_endp), .sof_out(sof),
      .sof_frame_out(sof_frame), .bus_reset_out(bus_rst), .req_valid_out(req_v),
      .req_out(req_d), .resp_valid_in(resp_v), .resp_in(resp_d));
   task automatic end_of_test();
      if (errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_sys_in);
   endtask
   // Bus cycles: request held until waitrequest is sampled low
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      adr <= a;
      wdat <= {24'h0, d};
      avs_wr <= 1'b1;
      @(posedge clk_sys_in);
      while (avs_waitrequest_out !== 1'b0) @(posedge clk_sys_in);
      avs_wr <= 1'b0;
   endtask
   task automatic rdck(input string nm, input logic [7:0] a, input logic [31:0] x);
      @(posedge clk_sys_in);
      adr <= a;
      avs_rd <= 1'b1;
      @(posedge clk_sys_in);
      while (avs_waitrequest_out !== 1'b0) @(posedge clk_sys_in);
      rdat = avs_readdata_out;
      avs_rd <= 1'b0;
      chk(nm, rdat, x);
   endtask
   task automatic rq(input usc_tok_type k, input logic [6:0] a, input logic [3:0] e,
                     input usc_rsp_type x);
      logic v;
      i_usc_host_model.req(k, a, e, lr, v);
      chk("resp_valid", v, 1);
      chk("resp_kind", lr.kind, x);
   endtask
   // Cycles between two eye-pattern edges
   task automatic per(input int div);
      logic p;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         p = eye_dp_out;
         while (eye_dp_out === p && n < 300) begin
            @(posedge clk_sys_in);
            n++;
         end
      end
      chk("eye_period", n, div);
   endtask
   // Hang guard
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      tick(10);
      sys_rst_in <= 1'b0;
      rdck("addr_rst", `USC_OFF_ADDRESS, 0);
      rdck("flags_rst", `USC_OFF_FLAGS, 0);
      rdck("unmapped", 8'h40, 0);
      for (i = 0; i < 4; i++) begin
         reg_wr(`USC_OFF_CONFIG, {3'h0, 1'b1, 1'b0, 1'(i), 2'(i)});
         tick(2);
         chk("fs", full_speed_out, 32'(i % 2));
         chk("ppm", pingpong_mode_out, 32'(i));
         chk("pu_idle", pullup_on_out, 0);
      end
      reg_wr(`USC_OFF_CONTROL, 8'h01);
      n = 0;
      repeat (4) begin
         @(posedge clk_sys_in);
         n += int'(pingpong_clear_out);
      end
      chk("pp_clear", n, 1);
      chk("pu_on", pullup_on_out, 1);
      reg_wr(`USC_OFF_CONTROL, 8'h03);
      tick(2);
      chk("pu_susp", pullup_on_out, 0);
      reg_wr(`USC_OFF_CONTROL, 8'h01);
      reg_wr(`USC_OFF_ADDRESS, 8'h05);
      be <= 4'h0;
      reg_wr(`USC_OFF_ADDRESS, 8'h33);
      be <= 4'hF;
      rdck("addr_be", `USC_OFF_ADDRESS, 5);
      i_usc_host_model.ev(3'h4, 11'h0);
      rdck("addr_busrst", `USC_OFF_ADDRESS, 0);
      rdck("busrst_flag", `USC_OFF_FLAGS, 2);
      reg_wr(`USC_OFF_FLAGS, 8'h02);
      reg_wr(`USC_OFF_ADDRESS, 8'h05);
      reg_wr(`USC_OFF_EP_BASE + 8'h04, 8'h16);
      reg_wr(`USC_OFF_EP_BASE + 8'h08, 8'h02);
      reg_wr(`USC_OFF_EP_BASE + 8'h0C, 8'h0E);
      rdck("ep1", `USC_OFF_EP_BASE + 8'h04, 32'h16);
      rq(TOK_OUT, 7'h05, 4'h1, RSP_ACCEPT);
      chk("hs_on", lr.handshake, 1);
      rq(TOK_SETUP, 7'h05, 4'h1, RSP_ACCEPT);
      rq(TOK_OUT, 7'h05, 4'h2, RSP_IGNORE);
      rq(TOK_IN, 7'h05, 4'h2, RSP_ACCEPT);
      chk("hs_off", lr.handshake, 0);
      rq(TOK_SETUP, 7'h05, 4'h3, RSP_IGNORE);
      rq(TOK_IN, 7'h06, 4'h1, RSP_IGNORE);
      i_usc_host_model.ev(3'h1, 11'h1);
      rdck("stall_set", `USC_OFF_EP_BASE + 8'h04, 32'h17);
      reg_wr(`USC_OFF_EP_BASE + 8'h04, 8'h16);
      rdck("stall_clr", `USC_OFF_EP_BASE + 8'h04, 32'h16);
      i_usc_host_model.ev(3'h2, 11'h5A3);
      rdck("frm_lo", `USC_OFF_FRAME_LOW, 32'hA3);
      rdck("frm_hi", `USC_OFF_FRAME_HIGH, 32'h05);
      // Five completions into four places: the last is dropped
      for (i = 0; i < 5; i++) begin
         i_usc_host_model.done(4'(i + 1), 1'(i), ~1'(i));
      end
      tick(4);
      rdck("flag_set", `USC_OFF_FLAGS, 1);
      rq(TOK_OUT, 7'h05, 4'h1, RSP_NAK);
      for (i = 0; i < 4; i++) begin
         rdck("status", `USC_OFF_STATUS, {25'h0, 4'(i + 1), 1'(i), ~1'(i), 1'b0});
         reg_wr(`USC_OFF_FLAGS, 8'h01);
         tick(4);
         rdck("flag_next", `USC_OFF_FLAGS, 32'(i < 3));
      end
      // Settings change only while the module is off
      for (i = 0; i < 2; i++) begin
         reg_wr(`USC_OFF_CONTROL, 8'h00);
         reg_wr(`USC_OFF_CONFIG, (i == 1) ? 8'h80 : 8'h84);
         tick(20);
         chk("eye_off", eye_oe_n_out, 1);
         reg_wr(`USC_OFF_CONTROL, 8'h01);
         tick(3);
         chk("eye_on", eye_oe_n_out, 0);
         chk("eye_start", eye_dp_out, 0);
         per((i == 1) ? `USC_LS_DIV : `USC_FS_DIV);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
